/* pfs_defs.svh */
// Constants of the program flow sequencer: opcodes, conditions,
// register offsets, reset values and field positions.
// Assumes inclusion by bare name; definitions only.
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// Instruction fields (18-bit word)
`define PFS_OP_HI    17
`define PFS_OP_LO    13
`define PFS_REGFORM  12
// Opcodes, 5 bits
`define PFS_OP_LOAD   5'h00
`define PFS_OP_INPUT  5'h02
`define PFS_OP_OUTPUT 5'h16
`define PFS_OP_RETURN 5'h15
`define PFS_OP_CALL   5'h18
`define PFS_OP_JUMP   5'h1a
`define PFS_OP_RETI   5'h1c
`define PFS_OP_INTEN  5'h1e
// Condition codes, 3 bits; bit 2 low means always
`define PFS_CC_ZERO_SET  3'h4
`define PFS_CC_ZERO_CLR  3'h5
`define PFS_CC_CARRY_SET 3'h6
`define PFS_CC_CARRY_CLR 3'h7
// Interrupt vector: last instruction location
`define PFS_VECTOR   10'h3ff
// APB byte offsets
`define PFS_REG_CTRL   12'h000
`define PFS_REG_FLAGS  12'h004
`define PFS_REG_STATUS 12'h008
// Reset values
`define PFS_RST_RUN    1'h1
`define PFS_RST_PC     10'h000
// Status field positions
`define PFS_ST_IE      16
`define PFS_ST_LVL     24

`endif

/* pfs_pkg.sv */
// Types shared by the program flow sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pfs_pkg;
  // Sequencer phase
  typedef enum logic [1:0] {
    ST_FETCH,
    ST_EXEC,
    ST_INT1,
    ST_INT2
  } pfs_state_t;
  typedef logic [9:0] pfs_addr_t;   // Program address
  typedef logic [7:0] pfs_byte_t;   // Data byte
endpackage : pfs_pkg

/* pfs_stack_if.sv */
// Carrier between the sequencer and its call/return stack.
// Assumes both ends run on the same clock.
interface pfs_stack_if;
  import pfs_pkg::*;
  logic      push;       // Push push_data this cycle
  logic      pop;        // Drop top entry this cycle
  pfs_addr_t push_data;  // Value pushed
  pfs_addr_t top;        // Current top entry
  logic [4:0] level;     // Stack pointer
  modport core  (output push, pop, push_data, input top, level);
  modport stack (input push, pop, push_data, output top, level);
endinterface : pfs_stack_if

/* pfs_stack.sv */
// Call/return stack of 32 program addresses.
// Assumes push and pop never come in the same cycle.
module pfs_stack
  import pfs_pkg::*;
(
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // Core side
  pfs_stack_if.stack stk
);
  pfs_addr_t  mem [32];  // Entries, not reset
  logic [4:0] ptr_q;     // Top index

  // Pointer wraps on overflow; deep nesting silently overwrites
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= 5'h00;
    end else if (stk.push) begin
      ptr_q <= ptr_q + 5'h01;
    end else if (stk.pop) begin
      ptr_q <= ptr_q - 5'h01;
    end
  end

  // Entry store
  always_ff @(posedge pclk) begin
    if (stk.push) begin
      mem[ptr_q + 5'h01] <= stk.push_data;
    end
  end

  assign stk.top   = mem[ptr_q];
  assign stk.level = ptr_q;
endmodule : pfs_stack

/* pfs_sequencer.sv */
// Program flow and interrupt sequencer of an 8-bit soft core.
// Assumes a synchronous instruction store (word valid one cycle
// after address) and port logic on the same clock as pclk.
//
// The address map and the APB slave port were left to the implementer.
`include "pfs_defs.svh"

module pfs_sequencer
  import pfs_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Instruction store
  output pfs_addr_t        address,
  input  wire logic [17:0] instruction,
  // Ports
  output pfs_byte_t        port_select,
  output pfs_byte_t        out_port,
  input  wire pfs_byte_t   in_port,
  output logic             read_strobe,
  output logic             write_strobe,
  // Interrupt
  input  wire logic        interrupt,
  output logic             interrupt_ack
);
  pfs_state_t state_q;     // Phase
  pfs_addr_t  pc_q;        // Program counter, never an operand
  logic       carry_q;     // Carry flag
  logic       zero_q;      // Zero flag
  logic       ie_q;        // Interrupt enable
  logic       sav_c_q;     // Carry saved at entry
  logic       sav_z_q;     // Zero saved at entry
  logic       run_q;       // Software run control
  logic       irq_s1_q;    // Synchroniser first stage
  logic       irq_s2_q;    // Synchroniser second stage
  pfs_byte_t  rf [16];     // Register file
  pfs_byte_t  psel_q;      // Port select out
  pfs_byte_t  outp_q;      // Output data
  logic       rd_stb_q;    // Read strobe
  logic       wr_stb_q;    // Write strobe
  logic       ack_q;       // Interrupt acknowledge
  logic       in_pend_q;   // Input write pending
  logic [3:0] in_dst_q;    // Input destination

  pfs_stack_if stk ();     // Stack carrier

  // Instruction fields
  logic [4:0] op;
  logic [2:0] cc;
  logic       reg_form;
  logic [3:0] dx;          // destination_register index
  logic [3:0] sy;          // second_register index
  pfs_byte_t  kk;          // immediate_constant
  pfs_addr_t  tgt;         // Absolute target
  assign op       = instruction[`PFS_OP_HI:`PFS_OP_LO];
  assign cc       = instruction[12:10];
  assign reg_form = instruction[`PFS_REGFORM];
  assign dx       = instruction[11:8];
  assign sy       = instruction[7:4];
  assign kk       = instruction[7:0];
  assign tgt      = instruction[9:0];

  // Decode, valid only in the execute phase
  logic exec;
  logic cond_ok;
  logic is_jump;
  logic is_call;
  logic is_ret;
  logic take_jump;
  logic take_call;
  logic take_ret;
  logic do_reti;
  logic do_ie;
  logic do_load;
  logic irq_take;
  assign exec = (state_q == ST_EXEC);

  // Condition tested against flags left by the previous instruction
  always_comb begin
    case (cc)
      `PFS_CC_ZERO_SET:  cond_ok = zero_q;
      `PFS_CC_ZERO_CLR:  cond_ok = !zero_q;
      `PFS_CC_CARRY_SET: cond_ok = carry_q;
      `PFS_CC_CARRY_CLR: cond_ok = !carry_q;
      default:           cond_ok = 1'b1;
    endcase
  end

  assign is_jump   = exec && (op == `PFS_OP_JUMP);
  assign is_call   = exec && (op == `PFS_OP_CALL);
  assign is_ret    = exec && (op == `PFS_OP_RETURN);
  assign take_jump = is_jump && cond_ok;
  assign take_call = is_call && cond_ok;
  assign take_ret  = is_ret && cond_ok;
  assign do_reti   = exec && (op == `PFS_OP_RETI);
  assign do_ie     = exec && (op == `PFS_OP_INTEN);
  assign do_load   = exec && (op == `PFS_OP_LOAD);
  // Enable-change instruction finishes first; entry uses new state
  assign irq_take  = exec && irq_s2_q && ie_q && !do_ie;

  // Interrupt pin synchroniser; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= interrupt;
      irq_s2_q <= irq_s1_q;
    end
  end

  // Phase machine: fetch then execute, two cycles per instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_FETCH;
    end else begin
      case (state_q)
        ST_FETCH: state_q <= run_q ? ST_EXEC : ST_FETCH;
        ST_EXEC:  state_q <= irq_take ? ST_INT1 : ST_FETCH;
        ST_INT1:  state_q <= ST_INT2;
        ST_INT2:  state_q <= ST_FETCH;
        default:  state_q <= ST_FETCH;
      endcase
    end
  end

  // Program counter; steps by one per executed instruction unless flow control, interrupt entry or reset loads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= `PFS_RST_PC;
    end else if (state_q == ST_INT1) begin
      pc_q <= `PFS_VECTOR;
    end else if (exec) begin
      if (take_jump || take_call) begin
        pc_q <= tgt;
      end else if (take_ret) begin
        pc_q <= stk.top + 10'h001;
      end else if (do_reti) begin
        pc_q <= stk.top;
      end else begin
        pc_q <= pc_q + 10'h001;
      end
    end
  end
  assign address = pc_q;

  // Stack traffic; jumps never appear here
  assign stk.push      = take_call || (state_q == ST_INT1);
  assign stk.pop       = take_ret || do_reti;
  assign stk.push_data = pc_q;

  pfs_stack u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .stk     (stk.stack)
  );

  // APB decode; zero wait states
  logic apb_wr;
  logic flag_wr;
  logic mapped;
  assign apb_wr  = psel && penable && pwrite;
  assign flag_wr = apb_wr && (paddr == `PFS_REG_FLAGS);
  assign mapped  = (paddr == `PFS_REG_CTRL) || (paddr == `PFS_REG_FLAGS)
                || (paddr == `PFS_REG_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read mux; status shows live sequencer state
  logic [31:0] rdata_d;    // Read value for the current address
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `PFS_REG_CTRL:   rdata_d[0] = run_q;
      `PFS_REG_FLAGS:  rdata_d[1:0] = {zero_q, carry_q};
      `PFS_REG_STATUS: begin
        rdata_d[9:0]            = pc_q;
        rdata_d[`PFS_ST_IE]     = ie_q;
        rdata_d[28:`PFS_ST_LVL] = stk.level;
      end
      default:         rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data taken in the setup phase so it stands from a flip-flop
  // through the access phase; status is a snapshot one cycle old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rdata_d;
    end
  end

  // Run control; halting parks the core between instructions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= `PFS_RST_RUN;
    end else if (apb_wr && (paddr == `PFS_REG_CTRL)) begin
      run_q <= pwdata[0];
    end
  end

  // Flags: software may preset them; only interrupt return
  // touches them in this block, loads, jumps, calls keep them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
    end else if (flag_wr) begin
      carry_q <= pwdata[0];
      zero_q  <= pwdata[1];
    end else if (do_reti) begin
      carry_q <= sav_c_q;
      zero_q  <= sav_z_q;
    end
  end

  // Flag copies taken on interrupt entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sav_c_q <= 1'b0;
      sav_z_q <= 1'b0;
    end else if (state_q == ST_INT1) begin
      sav_c_q <= carry_q;
      sav_z_q <= zero_q;
    end
  end

  // Interrupt enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= 1'b0;
    end else if (state_q == ST_INT1) begin
      ie_q <= 1'b0;
    end else if (do_ie || do_reti) begin
      ie_q <= instruction[0];
    end
  end

  // Acknowledge lands in the second entry cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (state_q == ST_INT1);
    end
  end
  assign interrupt_ack = ack_q;

  // Register file; input data lands one cycle after the strobe,
  // before the next instruction can read it
  always_ff @(posedge pclk) begin
    if (in_pend_q) begin
      rf[in_dst_q] <= in_port;
    end else if (do_load) begin
      rf[dx] <= reg_form ? rf[sy] : kk;
    end
  end

  // Port select, output data and strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel_q    <= 8'h00;
      outp_q    <= 8'h00;
      rd_stb_q  <= 1'b0;
      wr_stb_q  <= 1'b0;
      in_pend_q <= 1'b0;
      in_dst_q  <= 4'h0;
    end else begin
      rd_stb_q  <= 1'b0;
      wr_stb_q  <= 1'b0;
      in_pend_q <= 1'b0;
      if (exec && (op == `PFS_OP_INPUT)) begin
        psel_q    <= reg_form ? rf[sy] : kk;
        rd_stb_q  <= 1'b1;
        in_pend_q <= 1'b1;
        in_dst_q  <= dx;
      end else if (exec && (op == `PFS_OP_OUTPUT)) begin
        psel_q   <= reg_form ? rf[sy] : kk;
        outp_q   <= rf[dx];
        wr_stb_q <= 1'b1;
      end
    end
  end
  assign port_select  = psel_q;
  assign out_port     = outp_q;
  assign read_strobe  = rd_stb_q;
  assign write_strobe = wr_stb_q;

  // Checks on the sequencer
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_int_enter;
    (state_q == ST_INT1) ##1 (interrupt_ack && !ie_q && pc_q == `PFS_VECTOR);
  endsequence

  a_load_flags_hold: assert property (
    do_load && !flag_wr |=> $stable(carry_q) && $stable(zero_q))
    else $error("load changed a flag");
  a_load_imm_value: assert property (
    do_load && !reg_form && !in_pend_q |=> rf[$past(dx)] == $past(kk))
    else $error("immediate load wrote wrong value");
  a_pc_step_one: assert property (
    exec && !take_jump && !take_call && !take_ret && !do_reti
    |=> pc_q == $past(pc_q) + 10'h001)
    else $error("counter did not advance by one");
  a_jump_no_stack: assert property (
    is_jump |=> $stable(stk.level) && (state_q != ST_EXEC))
    else $error("jump touched stack or phase wrong");
  a_jump_target: assert property (
    take_jump && !flag_wr |=> pc_q == $past(tgt) && $stable(carry_q))
    else $error("jump target wrong");
  a_call_push: assert property (
    take_call |=> stk.top == $past(pc_q) && pc_q == $past(tgt))
    else $error("call push wrong");
  a_ret_pop: assert property (
    take_ret |=> pc_q == $past(stk.top) + 10'h001)
    else $error("return address wrong");
  a_call_flags: assert property (
    (is_call || is_ret) && !flag_wr |=> $stable(carry_q) && $stable(zero_q))
    else $error("call or return changed flags");
  a_irq_entry: assert property (
    irq_take |=> s_int_enter)
    else $error("interrupt entry sequence wrong");
  a_reti_restore: assert property (
    do_reti && !flag_wr
    |=> carry_q == $past(sav_c_q) && ie_q == $past(instruction[0]))
    else $error("interrupt return restore wrong");
  a_ack_once: assert property (
    $rose(interrupt_ack) |=> !interrupt_ack)
    else $error("acknowledge longer than one cycle");
endmodule : pfs_sequencer

/* pfs_store_model.sv */
// Partner model: synchronous instruction store, input data, interrupt source.
// Assumes it shares pclk with the sequencer; the bench loads mem.
module pfs_store_model
  import pfs_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Instruction store
  input  wire pfs_addr_t   address,
  output logic      [17:0] instruction,
  // Input port
  input  wire logic        read_strobe,
  output pfs_byte_t        in_port,
  // Interrupt source
  input  wire logic        irq_req,
  input  wire logic        interrupt_ack,
  output logic             interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] mem [1024];     // Program words
  pfs_byte_t   in_val = 8'ha7; // Data offered on reads
  // Word valid one cycle after its address, like a block RAM
  always_ff @(posedge pclk) begin
    instruction <= mem[address];
  end
  // Good only in the strobe cycle; inverted otherwise so a late sample shows
  assign in_port = read_strobe ? in_val : ~in_val;
  // Held until acknowledged, so always two cycles or more; low when unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      interrupt <= 1'b0;
    else if (interrupt_ack)
      interrupt <= 1'b0;
    else if (irq_req)
      interrupt <= 1'b1;
  end
endmodule : pfs_store_model

/* pfs_sequencer_test.sv */
// Bench for the sequencer: runs a short program from the store model and
// checks addresses, port traffic, registers and interrupt entry and return.
// Assumes pfs_store_model as instruction store and port partner.
`include "pfs_defs.svh"

module pfs_sequencer_test
  import pfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset and APB master
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Store, ports and interrupt
  pfs_addr_t   address;
  logic [17:0] instruction;
  pfs_byte_t   port_select;
  pfs_byte_t   out_port;
  pfs_byte_t   in_port;
  logic        read_strobe;
  logic        write_strobe;
  logic        interrupt;
  logic        interrupt_ack;
  logic        irq_req = 1'b0; // Request pulse to the model
  // Bookkeeping
  int          errors   = 0;
  int          n_checks = 0;
  int          cycles   = 0;
  int          gap      = 0;
  pfs_addr_t   last_a;
  pfs_addr_t   aq[$];  // Each new address
  int          gq[$];  // Cycles since previous change
  logic [15:0] wq[$];  // Writes as {port_select, out_port}
  pfs_byte_t   rq[$];  // Reads as port_select
  logic [31:0] rd;     // Last APB read data
  logic        er;     // Last APB error

  pfs_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .address, .instruction, .port_select, .out_port,
    .in_port, .read_strobe, .write_strobe, .interrupt, .interrupt_ack);
  pfs_store_model store (.pclk, .presetn, .address, .instruction, .read_strobe,
    .in_port, .irq_req, .interrupt_ack, .interrupt);

  always #50 pclk = ~pclk;

  // Whole run needs well under 1000 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end

  // Log address changes with their spacing, and port traffic
  always @(posedge pclk) begin
    gap++;
    if (!presetn) begin
      last_a = 10'h000;
      gap = 0;
    end else if (address !== last_a) begin
      aq.push_back(address);
      gq.push_back(gap);
      last_a = address;
      gap = 0;
    end
    if (write_strobe === 1'b1)
      wq.push_back({port_select, out_port});
    if (read_strobe === 1'b1)
      rq.push_back(port_select);
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // One APB transfer; holds everything until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Next logged address and, when eg is not 0, its spacing
  task automatic next_addr(input pfs_addr_t exp, input int eg);
    int n;
    while (aq.size() == 0) begin
      @(posedge pclk);
    end
    check(aq.pop_front(), exp);
    n = gq.pop_front();
    if (eg != 0)
      check(n, eg);
  endtask : next_addr

  task automatic load_prog();
    for (int i = 0; i < 1024; i++)
      store.mem[i] = {`PFS_OP_LOAD, 13'h1000}; // Copy s0 to itself: no effect
    store.mem[10'h000] = {`PFS_OP_LOAD, 13'h015a};   // s1 = 5a
    store.mem[10'h001] = {`PFS_OP_OUTPUT, 13'h0133}; // s1 to port 33
    store.mem[10'h002] = {`PFS_OP_LOAD, 13'h1210};   // s2 = s1
    store.mem[10'h003] = {`PFS_OP_LOAD, 13'h0344};   // s3 = 44
    store.mem[10'h004] = {`PFS_OP_OUTPUT, 13'h1230}; // s2 to port (s3)
    store.mem[10'h005] = {`PFS_OP_INPUT, 13'h0421};  // s4 from port 21
    store.mem[10'h006] = {`PFS_OP_OUTPUT, 13'h0422}; // s4 to port 22
    store.mem[10'h007] = {`PFS_OP_JUMP, 13'h1100};   // Zero set: not taken
    store.mem[10'h008] = {`PFS_OP_JUMP, 13'h1810};   // Carry set: taken
    store.mem[10'h010] = {`PFS_OP_CALL, 13'h1e00};   // Carry clear: not taken
    store.mem[10'h011] = {`PFS_OP_CALL, 13'h1600};   // Zero clear: taken
    store.mem[10'h200] = {`PFS_OP_RETURN, 13'h1000}; // Zero set: not taken
    store.mem[10'h201] = {`PFS_OP_RETURN, 13'h1800}; // Carry set: taken
    store.mem[10'h012] = {`PFS_OP_JUMP, 13'h1d00};   // Carry clear: not taken
    store.mem[10'h013] = {`PFS_OP_INTEN, 13'h0001};  // Enable interrupt
    store.mem[10'h014] = {`PFS_OP_JUMP, 13'h0015};
    store.mem[10'h015] = {`PFS_OP_JUMP, 13'h0014};
    store.mem[10'h3ff] = {`PFS_OP_JUMP, 13'h0300};
    store.mem[10'h300] = {`PFS_OP_JUMP, 13'h0301};
    store.mem[10'h301] = {`PFS_OP_RETI, 13'h0000};   // Return, stay disabled
  endtask : load_prog

  task automatic t_reset();
    check(address, 32'h0);
    check(port_select, 32'h0);
    check(out_port, 32'h0);
    check(interrupt_ack, 32'h0);
  endtask : t_reset

  // Moves, ports and every condition code, flags preset to carry=1 zero=0
  task automatic t_flow();
    pfs_addr_t seq [19] = '{10'h001, 10'h002, 10'h003, 10'h004, 10'h005, 10'h006,
      10'h007, 10'h008, 10'h010, 10'h011, 10'h200, 10'h201, 10'h012, 10'h013,
      10'h014, 10'h015, 10'h014, 10'h015, 10'h014};
    apb(1'b1, `PFS_REG_FLAGS, 32'h1);
    apb(1'b0, `PFS_REG_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, `PFS_REG_STATUS, 32'h0);
    check(rd & 32'h1f01_0000, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    check(er, 32'h1);
    check(rd, 32'h0);
    foreach (seq[i])
      next_addr(seq[i], (i == 0) ? 0 : 2);
    check(wq.size(), 32'h3);
    check(wq[0], 32'h335a);
    check(wq[1], 32'h445a);
    check(wq[2], 32'h22a7);
    check(rq[0], 32'h21);
    apb(1'b0, `PFS_REG_FLAGS, 32'h0);
    check(rd[1:0], 32'h1);
    apb(1'b0, `PFS_REG_STATUS, 32'h0);
    check(rd & 32'h1f01_0000, 32'h0001_0000);
  endtask : t_flow

  // Entry, handler disturbing flags, return, then a refused request
  task automatic t_interrupt();
    int n;
    int k;
    aq.delete();
    gq.delete();
    irq_req <= 1'b1;
    @(posedge pclk);
    irq_req <= 1'b0;
    n = 0;
    while (interrupt_ack !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    check(interrupt_ack, 32'h1);
    check(address, `PFS_VECTOR);
    @(posedge pclk);
    check(interrupt_ack, 32'h0);
    apb(1'b1, `PFS_REG_FLAGS, 32'h2);
    apb(1'b0, `PFS_REG_STATUS, 32'h0);
    check(rd[16], 32'h0);
    repeat (8) @(posedge pclk);
    k = 0;
    foreach (aq[i])
      if (aq[i] === `PFS_VECTOR && k == 0)
        k = i;
    check(aq[k + 1], 32'h300);
    check(aq[k + 2], 32'h301);
    check(aq[k + 3], aq[k - 1]);
    check(aq[k - 1] inside {10'h014, 10'h015}, 32'h1);
    apb(1'b0, `PFS_REG_FLAGS, 32'h0);
    check(rd[1:0], 32'h1);
    apb(1'b0, `PFS_REG_STATUS, 32'h0);
    check(rd & 32'h1f01_0000, 32'h0);
    irq_req <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge pclk);
      irq_req <= 1'b0;
      if (interrupt_ack === 1'b1)
        n++;
    end
    check(n, 32'h0);
  endtask : t_interrupt

  // Run control: a halted core parks, its counter no longer moves
  task automatic t_halt();
    logic [31:0] st0;
    apb(1'b1, `PFS_REG_CTRL, 32'h0);
    apb(1'b0, `PFS_REG_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `PFS_REG_STATUS, 32'h0);
    st0 = rd;
    repeat (7) @(posedge pclk);
    apb(1'b0, `PFS_REG_STATUS, 32'h0);
    check(rd, st0);
    apb(1'b1, `PFS_REG_CTRL, 32'h1);
  endtask : t_halt

  // Reset in mid-run: reset values return and the program restarts at zero
  task automatic t_midreset();
    aq.delete();
    gq.delete();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    t_reset();
    presetn <= 1'b1;
    next_addr(10'h001, 0);
    apb(1'b0, `PFS_REG_STATUS, 32'h0);
    check(rd & 32'h1f01_0000, 32'h0);
  endtask : t_midreset

  initial begin
    load_prog();
    repeat (12) @(posedge pclk);
    t_reset();
    presetn <= 1'b1;
    t_flow();
    t_interrupt();
    t_halt();
    t_midreset();
    finish_test();
  end
endmodule : pfs_sequencer_test
